// [ahb_host.sv]
// bus host model: single word AHB-Lite master for the execution unit.
// assumes one slave whose hreadyout is returned as hready_in.
`timescale 1ns/100ps
module ahb_host (
    input  wire logic        mclk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic      [31:0] haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [2:0]  hsize_out,
    output logic      [31:0] hwdata_out
);
    // idle bus at time zero, word size always
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end

    // wait until hready is high at a rising edge; q holds read data of that edge
    task automatic step(output logic [31:0] q);
        do @(negedge mclk_in); while (hready_in !== 1'b1);
        q = hrdata_in;
        @(posedge mclk_in);
    endtask : step

    // one transfer at byte offset a; released write data is inverted so it never looks valid
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_in);
        hsel_out <= 1'b1;
        haddr_out <= {24'h0, a};
        htrans_out <= 2'h2;
        hwrite_out <= wr;
        step(q);
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        step(q);
        hwdata_out <= ~d;
    endtask : xfer
endmodule : ahb_host

// [exec_monitor.sv]
// port checker for exec_unit: bus answer timing and execute/dummy cycles.
// assumes hready_in is fed from hreadyout_out and the bus does single word transfers.
`timescale 1ns/100ps
module exec_monitor (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_out,
    input  wire logic        hreadyout_out,
    input  wire logic        hresp_out,
    input  wire logic        busy_out,
    input  wire logic        skip_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // address phases taken by the slave
    logic acc_w;
    logic acc_r;
    logic cmd_w;
    assign acc_w = hsel_in & hready_in & htrans_in[1] & hwrite_in;
    assign acc_r = hsel_in & hready_in & htrans_in[1] & !hwrite_in;
    assign cmd_w = acc_w & (haddr_in[7:0] == 8'h00);

    resp_okay_a: assert property (hresp_out == 1'b0)
        else $error("slave gave an error response");
    read_wait_a: assert property (acc_r |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state is not one cycle");
    write_nowait_a: assert property (acc_w |=> hreadyout_out)
        else $error("write data phase stalled");
    unmapped_zero_a: assert property (acc_r && haddr_in[7:0] > 8'h30 |-> ##2 hrdata_out == 32'h0)
        else $error("unmapped read returned data");
    cmd_start_a: assert property (cmd_w && !busy_out ##1 !busy_out |=> busy_out)
        else $error("command did not start execution");
    exec_len_a: assert property (busy_out && !skip_out |=> !busy_out || skip_out)
        else $error("execute cycle longer than one cycle");
    dummy_one_a: assert property (skip_out |=> !busy_out)
        else $error("dummy cycle longer than one cycle");
    skip_after_a: assert property ($rose(skip_out) |-> busy_out && $past(busy_out) && !$past(skip_out))
        else $error("dummy cycle without execute cycle");
endmodule : exec_monitor

bind exec_unit exec_monitor mon (.mclk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .busy_out, .skip_out);

// [exec_pkg.sv]
// package for the instruction execution block: register map, field layout,
// memory sizes, reset values and the operation enumeration.
// assumes a single AHB-Lite master and word-only register access.
package exec_pkg;

    // memory geometry
    localparam int unsigned DM_AW      = 9;    // two data sections of 256 bytes
    localparam int unsigned PM_AW      = 10;   // four program pages of 256 words
    localparam int unsigned PAGE_AW    = 2;
    localparam logic [1:0]  LAST_PAGE  = 2'h3;

    // register byte offsets
    localparam logic [7:0] CMD_OFS     = 8'h00;
    localparam logic [7:0] ADDR_OFS    = 8'h04;
    localparam logic [7:0] IMM_OFS     = 8'h08;
    localparam logic [7:0] ACC_OFS     = 8'h0c;
    localparam logic [7:0] FLAGS_OFS   = 8'h10;
    localparam logic [7:0] TABLE_POINTER_LOW_OFS    = 8'h14;
    localparam logic [7:0] TABLE_POINTER_HIGH_OFS    = 8'h18;
    localparam logic [7:0] TABLE_HIGH_BYTE_REG_OFS    = 8'h1c;
    localparam logic [7:0] BANK_OFS    = 8'h20;
    localparam logic [7:0] STATUS_OFS  = 8'h24;
    localparam logic [7:0] DMDATA_OFS  = 8'h28;
    localparam logic [7:0] PMADDR_OFS  = 8'h2c;
    localparam logic [7:0] PMDATA_OFS  = 8'h30;

    // command register fields
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_BIT_LSB = 8;

    // flag register bit positions
    localparam int unsigned FLG_C  = 0;
    localparam int unsigned FLG_AC = 1;
    localparam int unsigned FLG_Z  = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_SC = 4;

    // status register bit positions
    localparam int unsigned STS_BUSY = 0;
    localparam int unsigned STS_SKIP = 1;

    // reset values
    localparam logic [7:0] BYTE_RST  = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    // decimal adjust constants
    localparam logic [3:0] BCD_MAX   = 4'h9;
    localparam logic [7:0] ADJ_LO    = 8'h06;
    localparam logic [7:0] ADJ_HI    = 8'h60;

    typedef enum logic [4:0] {
        op_nibble_swap_to_acc,
        op_skip_if_zero,
        op_skip_if_zero_move,
        op_skip_if_bit_zero,
        op_paged_table_read,
        op_last_page_table_read,
        op_preinc_paged_table_read,
        op_preinc_last_page_table_read,
        op_exclusive_or_to_acc,
        op_exclusive_or_to_memory,
        op_exclusive_or_imm,
        op_ext_add_carry,
        op_ext_add_carry_to_memory,
        op_ext_add,
        op_ext_add_to_memory,
        op_ext_bitwise_and,
        op_ext_bitwise_and_to_memory,
        op_ext_clear,
        op_ext_clear_bit,
        op_ext_complement,
        op_ext_complement_to_acc,
        op_ext_decimal_adjust,
        op_ext_decrement,
        op_ext_decrement_to_acc,
        op_ext_increment,
        op_ext_increment_to_acc,
        op_ext_move_to_acc,
        op_ext_move_to_memory
    } op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_dummy
    } state_t;

endpackage : exec_pkg

// [exec_unit.sv]
// execution unit for the nibble swap, zero skips, table reads, xor and the
// first extended long-address operations, with its own data and program memory.
// assumes one AHB-Lite master issuing single word transfers; hready = hreadyout.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module exec_unit
    import exec_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             busy_out,
    output logic             skip_out
);
    import exec_pkg::*;

    // adder result: {ov, ac, c, sum}
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] lo;
        s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {(a[7] == b[7]) && (s[7] != a[7]), lo[4], s[8], s[7:0]};
    endfunction : add8

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    logic [7:0]         dmem [0:(1 << DM_AW) - 1];
    logic [15:0]        pmem [0:(1 << PM_AW) - 1];

    state_t             state_q;
    op_t                op_q;
    logic [2:0]         bit_q;
    logic [DM_AW-1:0]   addr_q;
    logic [7:0]         imm_q;
    logic [7:0]         acc_q;
    logic [4:0]         flags_q;
    logic [7:0]         table_pointer_low_q;
    logic [7:0]         table_pointer_high_q;
    logic [7:0]         table_high_byte_reg_q;
    logic               bank_q;
    logic               skip_q;
    logic [PM_AW-1:0]   pm_addr_q;

    // bus address phase capture
    logic               dp_valid_q;
    logic               dp_write_q;
    logic [7:0]         dp_addr_q;
    logic               rd_wait_q;
    logic [31:0]        hrdata_q;

    logic               addr_phase;
    logic               wr_en;
    logic               rd_en;

    assign addr_phase    = hsel_in && hready_in && htrans_in[1];
    assign wr_en         = dp_valid_q && dp_write_q;
    assign rd_en         = dp_valid_q && !dp_write_q && rd_wait_q;
    assign hreadyout_out = !(dp_valid_q && !dp_write_q && !rd_wait_q);
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;
    assign busy_out      = state_q != st_idle;
    assign skip_out      = state_q == st_dummy;

    // address phase register; reads get one wait state to sample fresh data
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
            rd_wait_q  <= 1'b0;
        end else if (dp_valid_q && !dp_write_q && !rd_wait_q) begin
            rd_wait_q  <= 1'b1;
        end else begin
            dp_valid_q <= addr_phase;
            dp_write_q <= hwrite_in;
            dp_addr_q  <= haddr_in[7:0];
            rd_wait_q  <= 1'b0;
        end
    end

    // execution addresses
    logic [DM_AW-1:0]  ex_addr;
    logic [7:0]        mem_rd;
    logic [7:0]        ptr;
    logic [PM_AW-1:0]  tab_addr;
    logic [15:0]       tab_word;
    logic              ex_is_ext;

    always_comb begin
        ex_is_ext = op_q >= op_ext_add_carry;
        // short forms stay in the selected section, long forms reach any
        ex_addr   = ex_is_ext ? addr_q : {bank_q, addr_q[7:0]};
        mem_rd    = dmem[ex_addr];
        ptr       = (op_q == op_preinc_paged_table_read || op_q == op_preinc_last_page_table_read)
                    ? table_pointer_low_q + 8'h01 : table_pointer_low_q;
        if (op_q == op_last_page_table_read || op_q == op_preinc_last_page_table_read) begin
            tab_addr = {LAST_PAGE, ptr};
        end else begin
            tab_addr = {table_pointer_high_q[PAGE_AW-1:0], ptr};
        end
        tab_word  = pmem[tab_addr];
    end

    // operation datapath
    logic        acc_we;
    logic [7:0]  acc_wd;
    logic        mem_we;
    logic [7:0]  mem_wd;
    logic        table_high_byte_reg_we;
    logic        table_pointer_low_we;
    logic        do_skip;
    logic [4:0]  flags_nx;
    logic [10:0] sum;
    logic [7:0]  adj;
    logic [8:0]  dsum;

    always_comb begin
        acc_we   = 1'b0;
        acc_wd   = acc_q;
        mem_we   = 1'b0;
        mem_wd   = mem_rd;
        table_high_byte_reg_we  = 1'b0;
        table_pointer_low_we  = 1'b0;
        do_skip  = 1'b0;
        flags_nx = flags_q;
        sum      = add8(acc_q, mem_rd, flags_q[FLG_C] && (op_q == op_ext_add_carry
                                                       || op_q == op_ext_add_carry_to_memory));
        adj      = 8'h00;
        dsum     = 9'h000;
        case (op_q)
            op_nibble_swap_to_acc: begin
                acc_we = 1'b1;
                acc_wd = {mem_rd[3:0], mem_rd[7:4]};
            end
            op_skip_if_zero: begin
                mem_we  = 1'b1;
                do_skip = is_zero(mem_rd);
            end
            op_skip_if_zero_move: begin
                acc_we  = 1'b1;
                acc_wd  = mem_rd;
                do_skip = is_zero(mem_rd);
            end
            op_skip_if_bit_zero: begin
                do_skip = !mem_rd[bit_q];
            end
            op_paged_table_read, op_last_page_table_read,
            op_preinc_paged_table_read, op_preinc_last_page_table_read: begin
                mem_we  = 1'b1;
                mem_wd  = tab_word[7:0];
                table_high_byte_reg_we = 1'b1;
                table_pointer_low_we = op_q == op_preinc_paged_table_read
                          || op_q == op_preinc_last_page_table_read;
            end
            op_exclusive_or_to_acc, op_exclusive_or_to_memory, op_exclusive_or_imm: begin
                acc_wd = acc_q ^ ((op_q == op_exclusive_or_imm) ? imm_q : mem_rd);
                mem_wd = acc_wd;
                acc_we = op_q != op_exclusive_or_to_memory;
                mem_we = op_q == op_exclusive_or_to_memory;
                flags_nx[FLG_Z] = is_zero(acc_wd);
            end
            op_ext_add_carry, op_ext_add_carry_to_memory, op_ext_add, op_ext_add_to_memory: begin
                acc_wd = sum[7:0];
                mem_wd = sum[7:0];
                acc_we = op_q == op_ext_add_carry || op_q == op_ext_add;
                mem_we = !acc_we;
                flags_nx[FLG_C]  = sum[8];
                flags_nx[FLG_AC] = sum[9];
                flags_nx[FLG_OV] = sum[10];
                flags_nx[FLG_Z]  = is_zero(sum[7:0]);
                flags_nx[FLG_SC] = sum[10] ^ sum[7];
            end
            op_ext_bitwise_and, op_ext_bitwise_and_to_memory: begin
                acc_wd = acc_q & mem_rd;
                mem_wd = acc_wd;
                acc_we = op_q == op_ext_bitwise_and;
                mem_we = !acc_we;
                flags_nx[FLG_Z] = is_zero(acc_wd);
            end
            op_ext_clear: begin
                mem_we = 1'b1;
                mem_wd = 8'h00;
            end
            op_ext_clear_bit: begin
                mem_we = 1'b1;
                mem_wd[bit_q] = 1'b0;
            end
            op_ext_complement, op_ext_complement_to_acc: begin
                acc_wd = ~mem_rd;
                mem_wd = acc_wd;
                acc_we = op_q == op_ext_complement_to_acc;
                mem_we = !acc_we;
                flags_nx[FLG_Z] = is_zero(acc_wd);
            end
            op_ext_decimal_adjust: begin
                if (acc_q[3:0] > BCD_MAX || flags_q[FLG_AC]) begin
                    adj = adj | ADJ_LO;
                end
                if (acc_q[7:4] > BCD_MAX || flags_q[FLG_C]) begin
                    adj = adj | ADJ_HI;
                end
                dsum   = {1'b0, acc_q} + {1'b0, adj};
                mem_we = 1'b1;
                mem_wd = dsum[7:0];
                flags_nx[FLG_C] = flags_q[FLG_C] | dsum[8];
            end
            op_ext_decrement, op_ext_decrement_to_acc: begin
                acc_wd = mem_rd - 8'h01;
                mem_wd = acc_wd;
                acc_we = op_q == op_ext_decrement_to_acc;
                mem_we = !acc_we;
                flags_nx[FLG_Z] = is_zero(acc_wd);
            end
            op_ext_increment, op_ext_increment_to_acc: begin
                acc_wd = mem_rd + 8'h01;
                mem_wd = acc_wd;
                acc_we = op_q == op_ext_increment_to_acc;
                mem_we = !acc_we;
                flags_nx[FLG_Z] = is_zero(acc_wd);
            end
            op_ext_move_to_acc: begin
                acc_we = 1'b1;
                acc_wd = mem_rd;
            end
            op_ext_move_to_memory: begin
                mem_we = 1'b1;
                mem_wd = acc_q;
            end
            default: begin
                acc_we = 1'b0;
            end
        endcase
    end

    logic ex_go;
    assign ex_go = state_q == st_exec;

    // sequencer: one execute cycle, plus a dummy cycle when skipping
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= st_idle;
            op_q    <= op_ext_move_to_acc;
            bit_q   <= 3'h0;
            skip_q  <= 1'b0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (wr_en && dp_addr_q == CMD_OFS) begin
                        state_q <= st_exec;
                        op_q    <= op_t'(hwdata_in[CMD_OP_LSB +: 5]);
                        bit_q   <= hwdata_in[CMD_BIT_LSB +: 3];
                    end
                end
                st_exec: begin
                    skip_q  <= do_skip;
                    state_q <= do_skip ? st_dummy : st_idle;
                end
                st_dummy: begin
                    state_q <= st_idle;
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // software-only registers
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q    <= '0;
            imm_q     <= BYTE_RST;
            table_pointer_high_q    <= BYTE_RST;
            bank_q    <= 1'b0;
            pm_addr_q <= '0;
        end else if (wr_en) begin
            case (dp_addr_q)
                ADDR_OFS:   addr_q    <= hwdata_in[DM_AW-1:0];
                IMM_OFS:    imm_q     <= hwdata_in[7:0];
                TABLE_POINTER_HIGH_OFS:   table_pointer_high_q    <= hwdata_in[7:0];
                BANK_OFS:   bank_q    <= hwdata_in[0];
                PMADDR_OFS: pm_addr_q <= hwdata_in[PM_AW-1:0];
                default:    bank_q    <= bank_q;
            endcase
        end
    end

    // accumulator, flags and table registers: execution wins over software
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q   <= BYTE_RST;
            flags_q <= FLAGS_RST;
            table_pointer_low_q  <= BYTE_RST;
            table_high_byte_reg_q  <= BYTE_RST;
        end else if (ex_go) begin
            flags_q <= flags_nx;
            if (acc_we) begin
                acc_q <= acc_wd;
            end
            if (table_pointer_low_we) begin
                table_pointer_low_q <= ptr;
            end
            if (table_high_byte_reg_we) begin
                table_high_byte_reg_q <= tab_word[15:8];
            end
        end else if (wr_en) begin
            case (dp_addr_q)
                ACC_OFS:   acc_q   <= hwdata_in[7:0];
                FLAGS_OFS: flags_q <= hwdata_in[4:0];
                TABLE_POINTER_LOW_OFS:  table_pointer_low_q  <= hwdata_in[7:0];
                default:   acc_q   <= acc_q;
            endcase
        end
    end

    // memories: execution write takes priority over a software write
    always_ff @(posedge mclk_in) begin
        if (ex_go && mem_we) begin
            dmem[ex_addr] <= mem_wd;
        end else if (wr_en && dp_addr_q == DMDATA_OFS) begin
            dmem[addr_q] <= hwdata_in[7:0];
        end
        if (wr_en && dp_addr_q == PMDATA_OFS) begin
            pmem[pm_addr_q] <= hwdata_in[15:0];
        end
    end

    // read data sampled in the wait state; unmapped offsets read zero
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (dp_valid_q && !dp_write_q && !rd_wait_q) begin
            case (dp_addr_q)
                ADDR_OFS:   hrdata_q <= {23'h0, addr_q};
                IMM_OFS:    hrdata_q <= {24'h000000, imm_q};
                ACC_OFS:    hrdata_q <= {24'h000000, acc_q};
                FLAGS_OFS:  hrdata_q <= {27'h0, flags_q};
                TABLE_POINTER_LOW_OFS:   hrdata_q <= {24'h000000, table_pointer_low_q};
                TABLE_POINTER_HIGH_OFS:   hrdata_q <= {24'h000000, table_pointer_high_q};
                TABLE_HIGH_BYTE_REG_OFS:   hrdata_q <= {24'h000000, table_high_byte_reg_q};
                BANK_OFS:   hrdata_q <= {31'h0, bank_q};
                STATUS_OFS: hrdata_q <= {30'h0, skip_q, busy_out};
                DMDATA_OFS: hrdata_q <= {24'h000000, dmem[addr_q]};
                PMADDR_OFS: hrdata_q <= {22'h0, pm_addr_q};
                PMDATA_OFS: hrdata_q <= {16'h0000, pmem[pm_addr_q]};
                default:    hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

endmodule : exec_unit

// [tb_top.sv]
// top bench for exec_unit: runs every operation through the register bus and checks results.
// assumes the ahb_host model and the bound exec_monitor checker.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import exec_pkg::*;
    logic             mclk_in = 1'b0;
    logic             rst_n_in = 1'b0;
    logic             hsel_in, hwrite_in, hreadyout_out, hresp_out, busy_out, skip_out;
    logic      [31:0] haddr_in, hwdata_in, hrdata_out;
    logic      [1:0]  htrans_in;
    logic      [2:0]  hsize_in;
    wire logic        hready_in = hreadyout_out;
    int               n_mismatch = 0;
    int               samples_checked = 0;
    int               n_skip = 0;
    logic      [7:0]  va [3] = '{8'h3c, 8'h7f, 8'h9a};
    logic      [7:0]  vm [3] = '{8'h00, 8'hb7, 8'h80};
    logic      [4:0]  vf [3] = '{5'h03, 5'h00, 5'h1c};

    // clock and dummy cycle counter
    always #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (skip_out === 1'b1) n_skip <= n_skip + 1;

    exec_unit dut (.mclk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
        .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .busy_out, .skip_out);
    ahb_host host (.mclk_in(mclk_in), .hready_in(hready_in), .hrdata_in(hrdata_out), .hsel_out(hsel_in),
        .haddr_out(haddr_in), .htrans_out(htrans_in), .hwrite_out(hwrite_in), .hsize_out(hsize_in),
        .hwdata_out(hwdata_in));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd

    // start an operation and poll status until it is idle
    task automatic go(input op_t op, input logic [2:0] b);
        logic [31:0] q;
        wr(CMD_OFS, {21'h0, b, 3'h0, op});
        q = 32'h1;
        for (int i = 0; i < 8 && q[STS_BUSY] !== 1'b0; i++) rd(STATUS_OFS, q);
        `CHK(q[STS_BUSY], 1'b0)
    endtask : go

    // program word seeded per page so a wrong page shows in both bytes
    function automatic logic [15:0] tw(input logic [1:0] g, input logic [7:0] p);
        return {6'h2a, g, p + {g, 6'h00}};
    endfunction : tw

    // expected accumulator, memory, flags and skip of one operation
    function automatic void model(input op_t op, input logic [7:0] a, m, x, input logic [4:0] f,
        input logic [2:0] b, output logic [7:0] ea, em, output logic [4:0] ef, output logic sk);
        logic [8:0] s;
        logic [7:0] r;
        logic       ci, ov;
        int         k;
        ea = a; em = m; ef = f; sk = 1'b0; r = 8'h00; k = 0;
        case (op)
            op_nibble_swap_to_acc: ea = {m[3:0], m[7:4]};
            op_skip_if_zero: sk = (m == 8'h00);
            op_skip_if_zero_move: begin ea = m; sk = (m == 8'h00); end
            op_skip_if_bit_zero: sk = !m[b];
            op_exclusive_or_imm: begin r = a ^ x; k = 1; end
            op_exclusive_or_to_acc, op_exclusive_or_to_memory: begin r = a ^ m; k = 1; end
            op_ext_bitwise_and, op_ext_bitwise_and_to_memory: begin r = a & m; k = 1; end
            op_ext_complement, op_ext_complement_to_acc: begin r = ~m; k = 1; end
            op_ext_decrement, op_ext_decrement_to_acc: begin r = m - 8'h01; k = 1; end
            op_ext_increment, op_ext_increment_to_acc: begin r = m + 8'h01; k = 1; end
            op_ext_clear: em = 8'h00;
            op_ext_clear_bit: em[b] = 1'b0;
            op_ext_move_to_acc: ea = m;
            op_ext_move_to_memory: em = a;
            op_ext_decimal_adjust: begin
                s = {1'b0, a} + {1'b0, (a[3:0] > BCD_MAX || f[FLG_AC]) ? ADJ_LO : 8'h00}
                    + {1'b0, (a[7:4] > BCD_MAX || f[FLG_C]) ? ADJ_HI : 8'h00};
                em = s[7:0];
                ef[FLG_C] = f[FLG_C] | s[8];
            end
            default: begin
                ci = (op == op_ext_add_carry || op == op_ext_add_carry_to_memory) & f[FLG_C];
                s = {1'b0, a} + {1'b0, m} + {8'h0, ci};
                ov = (a[7] == m[7]) && (s[7] != a[7]);
                ef = {ov ^ s[7], ov, s[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ci}) > 5'h0f, s[8]};
                r = s[7:0];
                k = 2;
            end
        endcase
        if (k != 0 && op inside {op_exclusive_or_to_memory, op_ext_bitwise_and_to_memory, op_ext_complement,
            op_ext_decrement, op_ext_increment, op_ext_add_carry_to_memory, op_ext_add_to_memory}) em = r;
        else if (k != 0) ea = r;
        if (k == 1) ef[FLG_Z] = (r == 8'h00);
    endfunction : model

    task automatic results;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // watchdog, far beyond the few thousand cycles the sequence needs
    initial begin
        #1_000_000;
        n_mismatch++;
        results();
    end

    // reset, every operation except the table reads over three data sets, then the four table reads
    initial begin
        logic [31:0] q;
        logic [15:0] w;
        logic [7:0]  ea, em, tp;
        logic [4:0]  ef;
        logic        sk;
        int          ns;
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(8'h3c, q);
        `CHK(q, 32'h0)
        for (int v = 0; v < 3; v++) begin
            // the middle data set selects section 1 for the short forms
            wr(BANK_OFS, {31'h0, v[0]});
            for (int i = 0; i < 28; i++) begin
                if (i inside {[4:7]}) continue;
                // long forms point at the section that the bank does not select
                wr(ADDR_OFS, (i >= 11) ? {23'h0, !v[0], 8'ha5} : {23'h0, v[0], 8'h5a});
                wr(ACC_OFS, {24'h0, va[v]});
                wr(FLAGS_OFS, {27'h0, vf[v]});
                wr(IMM_OFS, 32'h55);
                wr(DMDATA_OFS, {24'h0, vm[v]});
                model(op_t'(i), va[v], vm[v], 8'h55, vf[v], 3'h5, ea, em, ef, sk);
                ns = n_skip;
                go(op_t'(i), 3'h5);
                rd(ACC_OFS, q);
                `CHK(q, {24'h0, ea})
                rd(FLAGS_OFS, q);
                `CHK(q, {27'h0, ef})
                rd(DMDATA_OFS, q);
                `CHK(q, {24'h0, em})
                rd(STATUS_OFS, q);
                `CHK(q[STS_SKIP], sk)
                `CHK(n_skip - ns, {31'h0, sk})
            end
        end
        wr(ADDR_OFS, 32'h05a);
        for (int g = 2; g < 4; g++) begin
            for (int p = 8'h41; p < 8'h44; p++) begin
                wr(PMADDR_OFS, {22'h0, 2'(g), 8'(p)});
                wr(PMDATA_OFS, {16'h0, tw(2'(g), 8'(p))});
            end
        end
        wr(TABLE_POINTER_HIGH_OFS, 32'h2);
        wr(TABLE_POINTER_LOW_OFS, 32'h41);
        tp = 8'h41;
        for (int k = 0; k < 4; k++) begin
            if (k >= 2) tp = tp + 8'h01;
            go(op_t'(4 + k), 3'h0);
            w = tw((k % 2 == 1) ? LAST_PAGE : 2'h2, tp);
            rd(DMDATA_OFS, q);
            `CHK(q, {24'h0, w[7:0]})
            rd(TABLE_HIGH_BYTE_REG_OFS, q);
            `CHK(q, {24'h0, w[15:8]})
            rd(TABLE_POINTER_LOW_OFS, q);
            `CHK(q, {24'h0, tp})
        end
        results();
    end
endmodule : tb_top
